/* hw/ubpc_top.sv */
/*
  ubpc_top: baud rate generator, rate-detect capture routing and Sleep/Idle
  behaviour of an asynchronous serial port, with an AXI4-Lite register slave.
  assumes: shifters and framing live outside and follow port_clk_en, the
  oversample tick and the abort pulses; sleep_mode/idle_mode come from the
  processor power controller and are synchronous to aclk.

*/
`timescale 1ns/10ps
module ubpc_top #(
  parameter int PORT_NUM = 1
) (
  input  wire  logic        aclk,
  input  wire  logic        aresetn,
  input  wire  logic [4:0]  s_axi_awaddr,
  input  wire  logic        s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire  logic [31:0] s_axi_wdata,
  input  wire  logic [3:0]  s_axi_wstrb,
  input  wire  logic        s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire  logic        s_axi_bready,
  input  wire  logic [4:0]  s_axi_araddr,
  input  wire  logic        s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire  logic        s_axi_rready,
  input  wire  logic        sleep_mode,
  input  wire  logic        idle_mode,
  input  wire  logic        tx_active,
  input  wire  logic        rx_active,
  input  wire  logic        tx_serial,
  input  wire  logic        serial_in_pin,
  output logic              serial_out_pin,
  output logic              capture_channel_one,
  output logic              capture_channel_two,
  output logic              port_clk_en,
  output logic              oversample_tick,
  output logic              tx_abort,
  output logic              rx_abort,
  output logic [1:0]        rx_irq_select,
  output logic              rx_edge_irq,
  output logic              wake_req,
  output logic              irq
);

  // ****************************************************************
  // register bus slave
  // ****************************************************************
  logic [15:0]          div_q;
  ubpc_pkg::ubpc_mode_t mode_q;
  logic [2:0]           istat_q;
  logic [2:0]           imask_q;
  logic                 bvalid_q;
  logic [1:0]           bresp_q;
  logic                 rvalid_q;
  logic [1:0]           rresp_q;
  logic [31:0]          rdata_q;
  logic                 wr_go;
  logic                 rd_go;
  ubpc_pkg::ubpc_status_t status;
  logic [15:0]          div_d;
  function automatic logic is_mapped(input logic [4:0] a);
    is_mapped = (a == ubpc_pkg::OFS_BAUD_DIV) || (a == ubpc_pkg::OFS_MODE) ||
                (a == ubpc_pkg::OFS_STATUS)   || (a == ubpc_pkg::OFS_IRQ_STAT) ||
                (a == ubpc_pkg::OFS_IRQ_MASK);
  endfunction
  // both channels are taken in the same edge; a lone one waits for its mate
  assign wr_go         = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign rd_go         = s_axi_arvalid && !rvalid_q;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
  logic div_wr;
  logic mode_wr;
  assign div_wr  = wr_go && (s_axi_awaddr == ubpc_pkg::OFS_BAUD_DIV);
  assign mode_wr = wr_go && (s_axi_awaddr == ubpc_pkg::OFS_MODE);
  assign div_d   = {s_axi_wstrb[1] ? s_axi_wdata[15:8] : div_q[15:8],
                    s_axi_wstrb[0] ? s_axi_wdata[7:0] : div_q[7:0]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= ubpc_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= is_mapped(s_axi_awaddr) ? ubpc_pkg::RESP_OKAY : ubpc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q  <= ubpc_pkg::RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rresp_q  <= is_mapped(s_axi_araddr) ? ubpc_pkg::RESP_OKAY : ubpc_pkg::RESP_SLVERR;
      if (s_axi_araddr == ubpc_pkg::OFS_BAUD_DIV) begin
        rdata_q <= {16'h0000, div_q};
      end else if (s_axi_araddr == ubpc_pkg::OFS_MODE) begin
        rdata_q <= {16'h0000, mode_q};
      end else if (s_axi_araddr == ubpc_pkg::OFS_STATUS) begin
        rdata_q <= {16'h0000, status};
      end else if (s_axi_araddr == ubpc_pkg::OFS_IRQ_STAT) begin
        rdata_q <= {29'h0000_0000, istat_q};
      end else if (s_axi_araddr == ubpc_pkg::OFS_IRQ_MASK) begin
        rdata_q <= {29'h0000_0000, imask_q};
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  // ****************************************************************
  // divisor and mode registers
  // ****************************************************************
  // full 16-bit divisor
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= ubpc_pkg::RST_BAUD_DIV;
    end else if (div_wr) begin
      div_q <= div_d;
    end
  end
  // only bus writes change these, sleep never touches them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= ubpc_pkg::RST_MODE;
    end else if (mode_wr) begin
      if (s_axi_wstrb[0]) mode_q[7:0]  <= s_axi_wdata[7:0];
      if (s_axi_wstrb[1]) mode_q[15:8] <= s_axi_wdata[15:8];
    end
  end
  // selection only passes to the receiver, the edge path ignores it
  assign rx_irq_select = mode_q.rx_irq_select;
  // ****************************************************************
  // power state and port clock
  // ****************************************************************
  logic sleep_q;
  logic idle_halt;
  logic sleep_enter;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_q <= 1'b0;
    end else begin
      sleep_q <= sleep_mode;
    end
  end

  assign sleep_enter = sleep_mode && !sleep_q;
  assign idle_halt   = idle_mode && mode_q.stop_in_idle;
  assign port_clk_en = mode_q.port_enable && !sleep_mode && !idle_halt;

  assign status = '{rsvd: 11'h000, port_clk_en: port_clk_en, idle_halt: idle_halt,
                    sleeping: sleep_q, rx_active: rx_active, tx_active: tx_active};

  // ****************************************************************
  // baud generator
  // ****************************************************************
  logic [15:0] cnt_q;
  logic        tick_q;
  // tick every divisor+1 clocks, reload on write
  // receiver/transmitter divide the tick by sixteen
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q  <= ubpc_pkg::RST_BAUD_DIV;
      tick_q <= 1'b0;
    end else if (div_wr || !port_clk_en) begin
      // a halted port restarts from a full period, so the first bit is never short
      cnt_q  <= div_wr ? div_d : div_q;
      tick_q <= 1'b0;
    end else if (cnt_q == 16'h0000) begin
      cnt_q  <= div_q;
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q - 16'h0001;
      tick_q <= 1'b0;
    end
  end

  assign oversample_tick = tick_q;
  // ****************************************************************
  // sleep abort and serial output
  // ****************************************************************
  logic tx_abort_q;
  logic rx_abort_q;
  logic sout_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_abort_q <= 1'b0;
      rx_abort_q <= 1'b0;
    end else begin
      tx_abort_q <= sleep_enter && tx_active;
      rx_abort_q <= sleep_enter && rx_active;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sout_q <= 1'b1;
    end else begin
      sout_q <= (sleep_mode || !mode_q.port_enable) ? 1'b1 : tx_serial;
    end
  end

  assign tx_abort       = tx_abort_q;
  assign rx_abort       = rx_abort_q;
  assign serial_out_pin = sout_q;

  assign capture_channel_one = mode_q.autobaud_en && (PORT_NUM == 1) && serial_in_pin;
  assign capture_channel_two = mode_q.autobaud_en && (PORT_NUM == 2) && serial_in_pin;

  // ****************************************************************
  // wake on falling edge
  // ****************************************************************
  logic rx_prev_q;
  logic edge_q;
  logic edge_d;
  // edge in sleep with wake bit and port enable
  assign edge_d = sleep_q && mode_q.wake_on_edge && mode_q.port_enable &&
                  rx_prev_q && !serial_in_pin;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_prev_q <= 1'b1;
      edge_q    <= 1'b0;
    end else begin
      rx_prev_q <= serial_in_pin;
      edge_q    <= edge_d;
    end
  end

  assign rx_edge_irq = edge_q;
  // wake only with receive interrupt enabled
  assign wake_req    = edge_q && mode_q.rx_irq_enable;

  // ****************************************************************
  // interrupt status and mask
  // ****************************************************************
  logic [2:0] ev;
  logic [2:0] w1c;
  assign ev  = {rx_abort_q, tx_abort_q, edge_q};
  assign w1c = (wr_go && (s_axi_awaddr == ubpc_pkg::OFS_IRQ_STAT) && s_axi_wstrb[0]) ?
               s_axi_wdata[2:0] : 3'h0;

  // an event in the clearing cycle wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      istat_q <= ubpc_pkg::RST_IRQ;
    end else begin
      istat_q <= (istat_q & ~w1c) | ev;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      imask_q <= ubpc_pkg::RST_IRQ;
    end else if (wr_go && (s_axi_awaddr == ubpc_pkg::OFS_IRQ_MASK) && s_axi_wstrb[0]) begin
      imask_q <= s_axi_wdata[2:0];
    end
  end

  assign irq = |(istat_q & imask_q);

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_sleep_tx;
    !sleep_q && sleep_mode && tx_active;
  endsequence

  AST_TICK_RELOAD: assert property (tick_q && port_clk_en && !div_wr |-> cnt_q == div_q)
    else $error("tick without reload");
  AST_TICK_PERIOD: assert property ($rose(tick_q) && div_q == 16'h0001 && port_clk_en && !div_wr
                                    ##1 (port_clk_en && !div_wr) |=> tick_q)
    else $error("tick period wrong");
  AST_DIV_WRITE: assert property (div_wr && s_axi_wstrb[1:0] == 2'h3 |=> div_q == $past(s_axi_wdata[15:0]))
    else $error("divisor write lost");
  AST_SLEEP_CLK: assert property (sleep_q && sleep_mode |-> !port_clk_en ##1 !tick_q)
    else $error("port clock runs in sleep");
  AST_TX_ABORT: assert property (s_sleep_tx |=> tx_abort && serial_out_pin)
    else $error("transmit not aborted");
  AST_RX_ABORT: assert property (!sleep_q && sleep_mode && rx_active |=> rx_abort)
    else $error("receive not aborted");
  AST_SLEEP_KEEP: assert property (sleep_q && !wr_go |=> $stable(div_q) && $stable(mode_q))
    else $error("register changed in sleep");
  AST_WAKE_EDGE: assert property (sleep_q && mode_q.wake_on_edge && mode_q.port_enable && rx_prev_q
                                  && !serial_in_pin |=> rx_edge_irq)
    else $error("edge interrupt missing");
  AST_EDGE_ENABLE: assert property (rx_edge_irq |-> $past(mode_q.port_enable))
    else $error("edge interrupt while disabled");
  AST_WAKE_REQ: assert property (rx_edge_irq && mode_q.rx_irq_enable |-> wake_req)
    else $error("wake request missing");
  AST_IDLE: assert property (idle_mode && !sleep_mode && mode_q.port_enable
                             |-> port_clk_en == !mode_q.stop_in_idle)
    else $error("idle halt wrong");
  AST_CAPTURE: assert property (mode_q.autobaud_en && PORT_NUM == 1
                                |-> capture_channel_one == serial_in_pin)
    else $error("capture routing wrong");

endmodule

/* hw/ubpc_pkg.sv */
/*
  ubpc_pkg: register map, field layout, reset values and carrier types for the
  serial port baud and power control block.
  assumes: 32-bit AXI4-Lite register bus, one aligned word per register.
*/
package ubpc_pkg;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [4:0] OFS_BAUD_DIV = 5'h00;
  localparam logic [4:0] OFS_MODE     = 5'h04;
  localparam logic [4:0] OFS_STATUS   = 5'h08;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h0c;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h10;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [15:0] RST_BAUD_DIV = 16'h0000;
  localparam logic [15:0] RST_MODE     = 16'h0000;
  localparam logic [2:0]  RST_IRQ      = 3'h0;

  // irq status / mask bit positions
  localparam int IRQ_WAKE_EDGE = 0;
  localparam int IRQ_TX_ABORT  = 1;
  localparam int IRQ_RX_ABORT  = 2;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // port_mode_reg layout; bit 7 is the sleep-exit-on-edge bit
  typedef struct packed {
    logic       port_enable;    // 15
    logic       rsvd14;         // 14
    logic       stop_in_idle;   // 13
    logic [4:0] rsvd12_8;       // 12:8
    logic       wake_on_edge;   // 7
    logic [1:0] rx_irq_select;  // 6:5
    logic       rx_irq_enable;  // 4
    logic [2:0] rsvd3_1;        // 3:1
    logic       autobaud_en;    // 0
  } ubpc_mode_t;

  // port_status_reg: live state of the block, read only
  typedef struct packed {
    logic [10:0] rsvd;
    logic        port_clk_en;
    logic        idle_halt;
    logic        sleeping;
    logic        rx_active;
    logic        tx_active;
  } ubpc_status_t;

endpackage

/* sim/ubpc_link_partner.sv */
/*
  ubpc_link_partner: remote serial transceiver seen from the serial input pin.
  assumes: same clock as the block; line_low asks for a space (start bit),
  answered LAG cycles later so slow partners can be mimicked.
*/
`timescale 1ns/10ps
module ubpc_link_partner #(
  parameter int LAG = 1
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic line_low,
  output logic      serial_in_pin
);
  logic [LAG-1:0] dly_q;

  // line idles at mark (high) out of reset and between characters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dly_q <= '0;
    end else begin
      dly_q <= LAG'({dly_q, line_low});
    end
  end

  assign serial_in_pin = ~dly_q[LAG-1];
endmodule

/* sim/tb_top.sv */
/*
  tb_top: self-checking bench for the baud and power control block.
  assumes: AXI4-Lite master tasks enter and leave just after a rising edge;
  outputs are sampled at the falling edge, where they have settled.
*/
`timescale 1ns/10ps
module tb_top;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        sleep_mode, idle_mode, tx_active, rx_active, tx_serial, line_low;
  logic        awready, wready, bvalid, arready, rvalid, serial_in_pin, serial_out_pin;
  logic        cap_one, cap_two, port_clk_en, oversample_tick, tx_abort, rx_abort;
  logic        rx_edge_irq, wake_req, irq;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rx_irq_select;
  int          fails = 0;
  int          cmp_count = 0;

  ubpc_top #(.PORT_NUM(1)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sleep_mode(sleep_mode),
    .idle_mode(idle_mode), .tx_active(tx_active), .rx_active(rx_active), .tx_serial(tx_serial),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .capture_channel_one(cap_one),
    .capture_channel_two(cap_two), .port_clk_en(port_clk_en), .oversample_tick(oversample_tick),
    .tx_abort(tx_abort), .rx_abort(rx_abort), .rx_irq_select(rx_irq_select),
    .rx_edge_irq(rx_edge_irq), .wake_req(wake_req), .irq(irq));

  ubpc_link_partner #(.LAG(1)) u_peer (
    .aclk(aclk), .aresetn(aresetn), .line_low(line_low), .serial_in_pin(serial_in_pin));

  always #20 aclk = ~aclk;

  // ****************************************************************
  // bus and compare tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic axw(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ak, wk, bk;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    bk = 1'h0;
    // slave may take address and data in either order
    while (!bk) begin
      @(negedge aclk);
      ak = awvalid & awready;
      wk = wvalid & wready;
      bk = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ak) awvalid <= 1'h0;
      if (wk) wvalid <= 1'h0;
    end
    bready <= 1'h0;
    @(posedge aclk);
  endtask

  task automatic axr(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ak, rk;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    rk = 1'h0;
    while (!rk) begin
      @(negedge aclk);
      ak = arvalid & arready;
      rk = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ak) arvalid <= 1'h0;
    end
    rready <= 1'h0;
    @(posedge aclk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk(r, ubpc_pkg::RESP_OKAY, "write response");
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] exp, input string m);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    chk(d, exp, m);
    chk(r, ubpc_pkg::RESP_OKAY, m);
  endtask

  // cycles between two ticks, counted at falling edges
  task automatic gap(output int n);
    n = 0;
    repeat (200) begin
      @(negedge aclk);
      if (oversample_tick) break;
    end
    do begin
      @(negedge aclk);
      n++;
    end while (!oversample_tick && n < 200);
    @(posedge aclk);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    @(negedge aclk);
    chk(port_clk_en, 0, "clock enable after reset");
    chk(serial_out_pin, 1, "serial out idle");
    chk(irq, 0, "irq after reset");
    @(posedge aclk);
    rdc(ubpc_pkg::OFS_BAUD_DIV, 0, "divisor reset");
    rdc(ubpc_pkg::OFS_MODE, 0, "mode reset");
    axr(5'h14, d, r);
    chk(r, ubpc_pkg::RESP_SLVERR, "unmapped read resp");
    chk(d, 0, "unmapped read data");
    axw(5'h14, 32'hffffffff, r);
    chk(r, ubpc_pkg::RESP_SLVERR, "unmapped write resp");
  endtask

  task automatic t_divisor;
    wr(ubpc_pkg::OFS_BAUD_DIV, 32'h1234abcd);
    rdc(ubpc_pkg::OFS_BAUD_DIV, 32'h0000abcd, "divisor upper bits");
    wr(ubpc_pkg::OFS_BAUD_DIV, 32'hffffffff);
    rdc(ubpc_pkg::OFS_BAUD_DIV, 32'h0000ffff, "divisor max");
    wstrb <= 4'h2;
    wr(ubpc_pkg::OFS_BAUD_DIV, 32'h00001200);
    wstrb <= 4'hf;
    rdc(ubpc_pkg::OFS_BAUD_DIV, 32'h000012ff, "divisor upper byte only");
  endtask

  task automatic t_tick;
    int n;
    int divs[3] = '{0, 3, 9};
    wr(ubpc_pkg::OFS_MODE, 32'h00008000);
    foreach (divs[i]) begin
      wr(ubpc_pkg::OFS_BAUD_DIV, divs[i]);
      gap(n);
      chk(n, divs[i] + 1, "tick period");
      chk(port_clk_en, 1, "port clock running");
    end
  endtask

  task automatic t_idle;
    wr(ubpc_pkg::OFS_MODE, 32'h0000a000);
    idle_mode <= 1'h1;
    @(negedge aclk);
    chk(port_clk_en, 0, "halt in idle");
    @(posedge aclk);
    rdc(ubpc_pkg::OFS_STATUS, 32'h00000008, "status idle halt");
    wr(ubpc_pkg::OFS_MODE, 32'h00008000);
    @(negedge aclk);
    chk(port_clk_en, 1, "run in idle");
    @(posedge aclk);
    idle_mode <= 1'h0;
  endtask

  task automatic t_sleep;
    int na, nr;
    wr(ubpc_pkg::OFS_BAUD_DIV, 32'h5);
    tx_serial <= 1'h0;
    tx_active <= 1'h1;
    rx_active <= 1'h1;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk(serial_out_pin, 0, "serial out follows data");
    @(posedge aclk);
    sleep_mode <= 1'h1;
    na = 0;
    nr = 0;
    repeat (5) begin
      @(negedge aclk);
      na += tx_abort;
      nr += rx_abort;
    end
    chk(na, 1, "tx abort pulse");
    chk(nr, 1, "rx abort pulse");
    chk(serial_out_pin, 1, "serial out high in sleep");
    chk(port_clk_en, 0, "clock stopped in sleep");
    chk(oversample_tick, 0, "no tick in sleep");
    @(posedge aclk);
    tx_active <= 1'h0;
    rx_active <= 1'h0;
    rdc(ubpc_pkg::OFS_BAUD_DIV, 32'h5, "divisor kept");
    rdc(ubpc_pkg::OFS_MODE, 32'h8000, "mode kept");
    sleep_mode <= 1'h0;
    tx_serial <= 1'h1;
    rdc(ubpc_pkg::OFS_IRQ_STAT, 32'h6, "abort events latched");
    chk(irq, 0, "masked events quiet");
    wr(ubpc_pkg::OFS_IRQ_STAT, 32'h7);
    rdc(ubpc_pkg::OFS_IRQ_STAT, 0, "events cleared");
  endtask

  task automatic t_wake(input logic [31:0] mode, input int exp_irq, input int exp_wake);
    int ne, nw;
    wr(ubpc_pkg::OFS_IRQ_MASK, 32'h1);
    wr(ubpc_pkg::OFS_MODE, mode);
    chk(rx_irq_select, mode[6:5], "select passthrough");
    sleep_mode <= 1'h1;
    repeat (3) @(posedge aclk);
    line_low <= 1'h1;
    ne = 0;
    nw = 0;
    repeat (6) begin
      @(negedge aclk);
      ne += rx_edge_irq;
      nw += wake_req;
    end
    chk(ne, exp_irq, "edge interrupt");
    chk(nw, exp_wake, "wake request");
    chk(irq, exp_irq, "irq level");
    @(posedge aclk);
    line_low <= 1'h0;
    sleep_mode <= 1'h0;
    wr(ubpc_pkg::OFS_IRQ_STAT, 32'h7);
    @(negedge aclk);
    chk(irq, 0, "irq cleared");
    @(posedge aclk);
  endtask

  task automatic t_capture;
    wr(ubpc_pkg::OFS_MODE, 32'h00008001);
    @(negedge aclk);
    chk(cap_one, 1, "capture one follows high");
    chk(cap_two, 0, "capture two unused");
    @(posedge aclk);
    line_low <= 1'h1;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk(cap_one, 0, "capture one follows low");
    @(posedge aclk);
    line_low <= 1'h0;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk(cap_one, 1, "capture one follows rise");
  endtask

  // ****************************************************************
  // run control
  // ****************************************************************
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    finish_test();
  end

  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {sleep_mode, idle_mode, tx_active, rx_active, line_low} = '0;
    tx_serial = 1'h1;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hf;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_reset();
    t_divisor();
    t_tick();
    t_idle();
    t_sleep();
    t_wake(32'h000080f0, 1, 1);
    t_wake(32'h00008090, 1, 1);
    t_wake(32'h000080e0, 1, 0);
    t_wake(32'h000000f0, 0, 0);
    t_wake(32'h00008070, 0, 0);
    t_capture();
    finish_test();
  end
endmodule
